// >>> inc/sir_consts.vh
// register offsets, field positions and reset values of the id and self-test bank
`ifndef SIR_CONSTS_VH
`define SIR_CONSTS_VH
`define SIR_IDX_SCRATCH_ONE 6'h2C
`define SIR_IDX_SCRATCH_TWO 6'h2D
`define SIR_IDX_VERSION 6'h2E
`define SIR_IDX_SELF_TEST_RESULT 6'h2F
`define SIR_REG_W 24
`define SIR_SCRATCH_RST 24'h00_0000
`define SIR_CODE_PASS 4'hA
`define SIR_CODE_FAIL 4'hF
`define SIR_SELF_TEST_RESULT_RST 24'h0A_AAAA
`define SIR_TYPE_LSB 16
`define SIR_REV_LSB 8
`define SIR_ROM_LSB 0
`define SIR_EXEC_LSB 16
`define SIR_DRAM_LSB 12
`define SIR_PROG_RAM_LSB 8
`define SIR_DATA_ROM_LSB 4
`define SIR_PROG_ROM_LSB 0
`define SIR_NUM_TESTS 5
`endif

// >>> core/sir_word_reg.v
// one 24-bit software register with reset value and optional load from hardware
`default_nettype none
module sir_word_reg #(
	parameter WIDTH = 24,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	input wire clk,
	input wire reset_n,
	input wire sw_we,
	input wire [WIDTH-1:0] sw_wdata,
	input wire [WIDTH-1:0] hw_mask,
	input wire [WIDTH-1:0] hw_wdata,
	output reg [WIDTH-1:0] value_q
);
	reg [WIDTH-1:0] value_d;

	// hardware load beats a software write on the same bits
	always @*
	begin
		value_d = value_q;
		if (sw_we)
			value_d = sw_wdata;
		value_d = (value_d & ~hw_mask) | (hw_wdata & hw_mask);
	end

	always @(posedge clk)
	begin
		if (!reset_n)
			value_q <= RST_VAL;
		else
			value_q <= value_d;
	end
endmodule // sir_word_reg
`default_nettype wire

// >>> core/sir_result_code.v
// turns a built-in test done/fail strobe pair into a field load
`default_nettype none
`include "sir_consts.vh"
module sir_result_code (
	input wire done,
	input wire fail,
	output wire load,
	output wire [3:0] code
);
	assign load = done;
	assign code = fail ? `SIR_CODE_FAIL : `SIR_CODE_PASS;
endmodule // sir_result_code
`default_nettype wire

// >>> core/sir_regs.v
// id, scratch and self-test register bank behind an APB slave
// Functional notes
// - two independent 24-bit scratch registers at 0x2C and 0x2D, all bits RW, reset to zero.
// - the scratch registers have no hardware effect and read back exactly what was written.
// - a version register at 0x2E holds chip type 23:16, hardware revision 15:8, ROM version 7:0.
// - a self-test register at 0x2F holds five 4-bit results: execution unit, RAMs and ROMs.
// - each result reads hex A for pass and hex F for fail.
// - the self-test register resets to zero in 23:20 and the pass code in every result field.
//
// Design decision made here: the APB interface to the registers.
`default_nettype none
`include "sir_consts.vh"
module sir_regs #(
	parameter [7:0] CHIP_TYPE = 8'h5A, // arbitrary value
	parameter [7:0] HW_REV = 8'h11, // arbitrary value
	parameter [7:0] ROM_VER = 8'h22 // arbitrary value
) (
	input wire CLK,
	input wire RESET_N,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	input wire [3:0] PSTRB,
	output wire PREADY,
	output wire PSLVERR,
	output reg [31:0] PRDATA,
	input wire [4:0] TEST_DONE,
	input wire [4:0] TEST_FAIL
);
	// -----------------------------------------------
	// bus decode
	// -----------------------------------------------
	localparam [23:0] VERSION_RST = {CHIP_TYPE, HW_REV, ROM_VER};

	function [23:0] merge_strb;
		input [23:0] old_v;
		input [23:0] new_v;
		input [3:0] strb;
		integer i;
		begin
			for (i = 0; i < 3; i = i + 1)
				merge_strb[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
		end
	endfunction

	wire [5:0] idx = PADDR[7:2];
	wire aligned = (PADDR[1:0] == 2'b00);
	wire hit_s1 = aligned && (idx == `SIR_IDX_SCRATCH_ONE);
	wire hit_s2 = aligned && (idx == `SIR_IDX_SCRATCH_TWO);
	wire hit_ver = aligned && (idx == `SIR_IDX_VERSION);
	wire hit_st = aligned && (idx == `SIR_IDX_SELF_TEST_RESULT);
	wire mapped = hit_s1 | hit_s2 | hit_ver | hit_st;
	wire access = PSEL && PENABLE;
	wire wr = access && PWRITE && mapped;

	// zero wait states; unmapped addresses answer with an error
	assign PREADY = 1'b1;
	assign PSLVERR = access && !mapped;

	wire [23:0] s1_q;
	wire [23:0] s2_q;
	wire [23:0] ver_q;
	wire [23:0] st_q;

	// -----------------------------------------------
	// registers
	// -----------------------------------------------
	sir_word_reg #(.WIDTH(24), .RST_VAL(`SIR_SCRATCH_RST)) u_s1 (
		.clk(CLK), .reset_n(RESET_N), .sw_we(wr && hit_s1),
		.sw_wdata(merge_strb(s1_q, PWDATA[23:0], PSTRB)),
		.hw_mask(24'h00_0000), .hw_wdata(24'h00_0000), .value_q(s1_q));

	sir_word_reg #(.WIDTH(24), .RST_VAL(`SIR_SCRATCH_RST)) u_s2 (
		.clk(CLK), .reset_n(RESET_N), .sw_we(wr && hit_s2),
		.sw_wdata(merge_strb(s2_q, PWDATA[23:0], PSTRB)),
		.hw_mask(24'h00_0000), .hw_wdata(24'h00_0000), .value_q(s2_q));

	// version fields are writable too, reset to the build values
	sir_word_reg #(.WIDTH(24), .RST_VAL(VERSION_RST)) u_ver (
		.clk(CLK), .reset_n(RESET_N), .sw_we(wr && hit_ver),
		.sw_wdata(merge_strb(ver_q, PWDATA[23:0], PSTRB)),
		.hw_mask(24'h00_0000), .hw_wdata(24'h00_0000), .value_q(ver_q));

	// -----------------------------------------------
	// self-test result loading
	// -----------------------------------------------
	wire [4:0] ld;
	wire [19:0] codes;
	genvar g;
	generate
		for (g = 0; g < `SIR_NUM_TESTS; g = g + 1)
		begin : g_res
			sir_result_code u_code (
				.done(TEST_DONE[g]), .fail(TEST_FAIL[g]),
				.load(ld[g]), .code(codes[g*4 +: 4]));
		end
	endgenerate

	// index 0..4 = program rom, data rom, program ram, data ram, execution unit
	wire [23:0] st_mask = {4'h0, {4{ld[4]}}, {4{ld[3]}}, {4{ld[2]}}, {4{ld[1]}}, {4{ld[0]}}};
	wire [23:0] st_hw = {4'h0, codes};

	sir_word_reg #(.WIDTH(24), .RST_VAL(`SIR_SELF_TEST_RESULT_RST)) u_st (
		.clk(CLK), .reset_n(RESET_N), .sw_we(wr && hit_st),
		.sw_wdata(merge_strb(st_q, PWDATA[23:0], PSTRB)),
		.hw_mask(st_mask), .hw_wdata(st_hw), .value_q(st_q));

	// -----------------------------------------------
	// read data
	// -----------------------------------------------
	always @(posedge CLK)
	begin
		if (!RESET_N)
			PRDATA <= 32'h0000_0000;
		else if (PSEL && !PENABLE && !PWRITE)
		begin
			case (1'b1)
				hit_s1: PRDATA <= {8'h00, s1_q};
				hit_s2: PRDATA <= {8'h00, s2_q};
				hit_ver: PRDATA <= {8'h00, ver_q};
				hit_st: PRDATA <= {8'h00, st_q};
				default: PRDATA <= 32'h0000_0000;
			endcase
		end
	end
endmodule // sir_regs
`default_nettype wire

// >>> verification/sir_regs_properties.sv
// port checker for the id and self-test register bank
`default_nettype none
module sir_regs_properties (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic PSLVERR,
	input wire logic [31:0] PRDATA,
	input wire logic [4:0] TEST_DONE,
	input wire logic [4:0] TEST_FAIL
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	sequence rd(a);
		PSEL && !PENABLE && !PWRITE && PADDR == a;
	endsequence
	pad_zero_a: assert property (PRDATA[31:24] == 8'h00) else $error("pad");
	test_rst_a: assert property ($rose(RESET_N) && PSEL && !PENABLE && !PWRITE
		&& PADDR == 8'hBC |=> PRDATA == 32'h000A_AAAA) else $error("test reset");
	fail_code_a: assert property (TEST_DONE[0] && TEST_FAIL[0] ##1 rd(8'hBC)
		|=> PRDATA[3:0] == 4'hF) else $error("fail code");
	pass_code_a: assert property (TEST_DONE[4] && !TEST_FAIL[4] ##1 rd(8'hBC)
		|=> PRDATA[19:16] == 4'hA) else $error("pass code");
	hole_err_a: assert property (PSEL && PENABLE && PADDR == 8'hC0 |-> PSLVERR)
		else $error("hole");
	map_ok_a: assert property (PSEL && PENABLE && PADDR == 8'hB8 |-> !PSLVERR)
		else $error("mapped");
	scratch_echo_a: assert property (PSEL && PENABLE && PWRITE && PADDR == 8'hB4
		##1 rd(8'hB4) |=> PRDATA[23:0] == $past(PWDATA[23:0], 2)) else $error("echo");
endmodule // sir_regs_properties
bind sir_regs sir_regs_properties sir_regs_properties_i (.CLK(CLK), .RESET_N(RESET_N),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PSLVERR(PSLVERR), .PRDATA(PRDATA), .TEST_DONE(TEST_DONE), .TEST_FAIL(TEST_FAIL));
`default_nettype wire

// >>> verification/sir_regs_tb_top.sv
// self-checking bench for the id and self-test register bank
`default_nettype none
module sir_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, e;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 0, PRDATA, r, sd = 32'h073a_2b33;
	logic [4:0] TEST_DONE = 0, TEST_FAIL = 0;
	logic [3:0] PSTRB = 4'hF;
	logic [23:0] m [4];
	int mismatches = 0, checked = 0;
	always #5 CLK = ~CLK;
	sir_regs sir_regs_i (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .PRDATA(PRDATA), .TEST_DONE(TEST_DONE), .TEST_FAIL(TEST_FAIL));
	function automatic logic [31:0] lf(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checked++;
		if (g !== x)
		begin
			mismatches++;
			$display("mismatch %0t got %h want %h", $time, g, x);
		end
	endtask
	// transfers run back to back; the caller drops psel when idle
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		PSEL <= 1;
		PENABLE <= 0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1;
		do
			@(posedge CLK);
		while (PREADY !== 1'b1);
		r = PRDATA;
		e = PSLVERR;
		// lane 3 has no register bits behind it
		if (w && a[7:4] == 4'hB && a[1:0] == 2'b00)
			for (int k = 0; k < 3; k++)
				if (PSTRB[k])
					m[a[3:2]][8 * k +: 8] = d[8 * k +: 8];
	endtask
	task automatic give_verdict;
		if (mismatches == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		m = '{24'h00_0000, 24'h00_0000, 24'h5A_1122, 24'h0A_AAAA};
		repeat (10) @(posedge CLK);
		RESET_N <= 1;
		for (int i = 3; i >= 0; i--)
		begin
			apb(0, 8'hB0 + 8'(4 * i), 0);
			chk(r, {8'h00, m[i]});
		end
		for (int i = 0; i < 8; i++)
		begin
			sd = lf(sd);
			apb(1, 8'hB0 + 8'(4 * (i % 4)), sd);
			apb(0, 8'hB0 + 8'(4 * (i % 4)), 0);
			chk(r, {8'h00, m[i % 4]});
		end
		PSTRB <= 4'h5;
		sd = lf(sd);
		apb(1, 8'hB0, sd);
		PSTRB <= 4'hF;
		apb(0, 8'hB0, 0);
		chk(r, {8'h00, m[0]});
		for (int i = 0; i < 2; i++)
		begin
			apb(1, 8'hB1 + 8'(15 * i), sd);
			chk(32'(e), 1);
			apb(0, 8'hB1 + 8'(15 * i), 0);
			chk(r, 0);
		end
		apb(1, 8'hBC, 0);
		for (int i = 0; i < 5; i++)
		begin
			PSEL <= 0;
			PENABLE <= 0;
			TEST_DONE <= 5'(1 << i);
			TEST_FAIL <= (i < 2) ? 5'h1F : 5'h00;
			m[3][4 * i +: 4] = (i < 2) ? 4'hF : 4'hA;
			@(posedge CLK);
			TEST_DONE <= 0;
			apb(0, 8'hBC, 0);
			chk(r, {8'h00, m[3]});
		end
		PSEL <= 0;
		PENABLE <= 0;
		@(posedge CLK);
		give_verdict();
	end
	initial
	begin
		#20000;
		mismatches++;
		give_verdict();
	end
endmodule // sir_regs_tb_top
`default_nettype wire
